// File: logic/pll_synth_divider_control.sv
// divider and phase detectors for three synthesizer loops, dual-modulus control for the two main loops
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pll_synth_divider_control (
  input  wire logic                  core_clk,        // 100 MHz system clock
  input  wire logic                  rst_n,           // synchronous reset, active low
  // apb slave
  input  wire logic                  psel,            // slave select
  input  wire logic                  penable,         // access phase
  input  wire logic                  pwrite,          // write when high
  input  wire logic [7:0]            paddr,           // byte address
  input  wire logic [31:0]           pwdata,          // write data
  output logic      [31:0]           prdata,          // read data, registered
  output logic                       pready,          // always ready
  output logic                       pslverr,         // unmapped address
  // analog-side pins
  input  wire logic                  ref_osc_in,      // reference oscillator
  input  wire logic [1:0]            prescaled_in,    // prescaler outputs, 0 tx 1 rx
  input  wire logic                  second_local_osc_vco, // internal vco clock
  output logic      [1:0]            modulus_ctl,     // prescaler modulus, 0 tx 1 rx
  output logic                       modulus_vmode,   // 1 voltage, 0 current drive
  output pll_synth_pkg::pump_s [1:0] main_pump,       // main loop pumps
  output logic      [1:0]            main_gain_hi,    // main pump high gain
  output pll_synth_pkg::pump_s       lo2_pump,        // second oscillator pump
  output logic                       lo2_gain_hi,     // second pump high gain
  output logic      [2:0]            lo2_cap_sel,     // tank capacitor code
  output logic                       lo2_buf_out      // buffered oscillator output
);

  //----------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------
  // pump decode: polarity swaps up/down; both or neither leaves high-z
  function automatic pll_synth_pkg::pump_s pump_decode(input logic up,
                                                       input logic dn,
                                                       input logic pol);
    pll_synth_pkg::pump_s p;
    p.drive = (up ^ pol);                    // source when effective up
    p.oe_n  = ~(up ^ dn);
    return p;
  endfunction

  //----------------------------------------------------------------------
  // configuration registers
  //----------------------------------------------------------------------
  logic [31:0] tx_word;                      // transmit loop word
  logic [31:0] rx_word;                      // receive loop word
  logic [31:0] lo2_word;                     // second oscillator word
  logic [31:0] ref_word;                     // reference word

  wire setup_phase = psel & ~penable;        // address valid, capture read
  wire access_wr   = psel & penable & pwrite; // write commits here
  wire hit_tx      = (paddr == pll_synth_pkg::TX_CFG_ADDR);
  wire hit_rx      = (paddr == pll_synth_pkg::RX_CFG_ADDR);
  wire hit_lo2     = (paddr == pll_synth_pkg::LO2_CFG_ADDR);
  wire hit_ref     = (paddr == pll_synth_pkg::REF_CFG_ADDR);
  wire hit_stat    = (paddr == pll_synth_pkg::STATUS_ADDR);
  wire mapped      = hit_tx | hit_rx | hit_lo2 | hit_ref | hit_stat;

  // only the documented bits are kept; everything else reads zero
  wire [31:0] main_mask = 32'h003F_FFFF;
  wire [31:0] lo2_mask  = 32'h0001_FFFF;
  wire [31:0] ref_mask  = 32'h001C_0FFF;

  // config port stays live regardless of loop state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_word  <= pll_synth_pkg::CFG_RESET;
      rx_word  <= pll_synth_pkg::CFG_RESET;
      lo2_word <= pll_synth_pkg::CFG_RESET;
      ref_word <= pll_synth_pkg::CFG_RESET;
    end else if (access_wr) begin
      if (hit_tx)  tx_word  <= pwdata & main_mask;
      if (hit_rx)  rx_word  <= pwdata & main_mask;
      if (hit_lo2) lo2_word <= pwdata & lo2_mask;
      if (hit_ref) ref_word <= pwdata & ref_mask;
    end
  end

  // separate configuration per main loop
  pll_synth_pkg::main_cfg_s [1:0] main_cfg;
  assign main_cfg[0] = tx_word[pll_synth_pkg::MAIN_POL:0];
  assign main_cfg[1] = rx_word[pll_synth_pkg::MAIN_POL:0];

  wire [pll_synth_pkg::LO2_CNT_W-1:0] lo2_cnt_cfg =
    lo2_word[pll_synth_pkg::LO2_CNT_LSB +: pll_synth_pkg::LO2_CNT_W];
  wire [pll_synth_pkg::REF_CNT_W-1:0] ref_cnt_cfg =
    ref_word[pll_synth_pkg::REF_CNT_LSB +: pll_synth_pkg::REF_CNT_W];

  //----------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------
  // stage 1 is read only by stage 2; stage 3 keeps history for edges
  logic [3:0] sync1;                         // first flops
  logic [3:0] sync2;                         // second flops, safe to use
  logic [3:0] sync3;                         // previous value for edge find
  wire  [3:0] raw_in = {second_local_osc_vco, prescaled_in, ref_osc_in};
  wire  [3:0] rise   = sync2 & ~sync3;       // one-cycle rising edge pulses

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  //----------------------------------------------------------------------
  // shared reference divider
  //----------------------------------------------------------------------
  // a zero count behaves as divide by one rather than stalling the loops
  logic [pll_synth_pkg::REF_CNT_W-1:0] ref_cnt;
  wire ref_tick = rise[0] & (ref_cnt <= 12'h001);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_cnt <= 12'h000;
    end else if (rise[0]) begin
      ref_cnt <= ref_tick ? ref_cnt_cfg : ref_cnt - 12'h001;
    end
  end

  //----------------------------------------------------------------------
  // main loops: dual-modulus counters and phase detectors
  //----------------------------------------------------------------------
  logic [1:0] mod_q;                         // modulus state per loop
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_main
      logic [pll_synth_pkg::MAIN_W-1:0]    n_cnt;   // main count left
      logic [pll_synth_pkg::SWALLOW_W-1:0] a_cnt;   // swallow count left
      logic                                up_q;    // reference led
      logic                                dn_q;    // divided signal led
      wire pulse    = rise[g + 1];                  // one prescaler pulse
      wire div_tick = pulse & (n_cnt <= 13'h0001);  // end of divide cycle
      // counts are software's job: main = total/P, swallow = remainder

      // swallow first at P+1, then main alone at P, then reload
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          n_cnt    <= 13'h0000;
          a_cnt    <= 7'h00;
          mod_q[g] <= 1'b0;
        end else if (div_tick) begin
          n_cnt    <= main_cfg[g].main_cnt;
          a_cnt    <= main_cfg[g].swallow_cnt;
          mod_q[g] <= (main_cfg[g].swallow_cnt != 7'h00);
        end else if (pulse) begin
          n_cnt    <= n_cnt - 13'h0001;
          if (a_cnt != 7'h00) begin
            a_cnt <= a_cnt - 7'h01;
          end
          mod_q[g] <= (a_cnt > 7'h01);
        end
      end

      // edge detector: coincident edges set nothing, both set clears
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          up_q <= 1'b0;
          dn_q <= 1'b0;
        end else if ((up_q | ref_tick) & (dn_q | div_tick)) begin
          up_q <= 1'b0;
          dn_q <= 1'b0;
        end else begin
          up_q <= up_q | ref_tick;
          dn_q <= dn_q | div_tick;
        end
      end

      // pump and gain pins registered for clean edges
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          main_pump[g]    <= '{drive: 1'b0, oe_n: 1'b1};
          main_gain_hi[g] <= 1'b0;
        end else begin
          main_pump[g]    <= pump_decode(up_q, dn_q, main_cfg[g].pol);
          main_gain_hi[g] <= main_cfg[g].gain;
        end
      end
    end
  endgenerate

  //----------------------------------------------------------------------
  // second local oscillator loop
  //----------------------------------------------------------------------
  logic [pll_synth_pkg::LO2_CNT_W-1:0] lo2_cnt; // count left
  logic                                lo2_up;  // reference led
  logic                                lo2_dn;  // divided vco led
  wire lo2_tick = rise[3] & (lo2_cnt <= 14'h0001);

  // divide the internal vco by the programmed count
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lo2_cnt <= 14'h0000;
    end else if (rise[3]) begin
      lo2_cnt <= lo2_tick ? lo2_cnt_cfg : lo2_cnt - 14'h0001;
    end
  end

  // same edge detector as the main loops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lo2_up <= 1'b0;
      lo2_dn <= 1'b0;
    end else if ((lo2_up | ref_tick) & (lo2_dn | lo2_tick)) begin
      lo2_up <= 1'b0;
      lo2_dn <= 1'b0;
    end else begin
      lo2_up <= lo2_up | ref_tick;
      lo2_dn <= lo2_dn | lo2_tick;
    end
  end

  // the internal vco is non-inverting, so polarity normally stays 0
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lo2_pump    <= '{drive: 1'b0, oe_n: 1'b1};
      lo2_gain_hi <= 1'b0;
      lo2_cap_sel <= 3'h0;
      lo2_buf_out <= 1'b0;
    end else begin
      lo2_pump    <= pump_decode(lo2_up, lo2_dn,
                                 lo2_word[pll_synth_pkg::LO2_POL]);
      lo2_gain_hi <= lo2_word[pll_synth_pkg::LO2_GAIN];
      lo2_cap_sel <= ref_word[pll_synth_pkg::CAP_LSB +: pll_synth_pkg::CAP_W];
      lo2_buf_out <= sync2[3];
    end
  end

  //----------------------------------------------------------------------
  // modulus pins
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modulus_ctl   <= 2'b00;
      modulus_vmode <= 1'b0;
    end else begin
      modulus_ctl   <= mod_q;
      modulus_vmode <= lo2_word[pll_synth_pkg::MOD_VMODE];
    end
  end

  //----------------------------------------------------------------------
  // apb read path
  //----------------------------------------------------------------------
  // status: {lo2 drive, lo2 oe_n, rx drive, rx oe_n, tx drive, tx oe_n, mod}
  wire [31:0] status_word = {24'h000000, lo2_pump, main_pump, mod_q};
  wire [31:0] read_mux =
      hit_tx   ? tx_word  :
      hit_rx   ? rx_word  :
      hit_lo2  ? lo2_word :
      hit_ref  ? ref_word :
      hit_stat ? status_word : 32'h0000_0000;

  // read data captured in setup so the access phase completes at once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : read_mux;
    end
  end

  assign pready  = 1'b1;                         // zero wait states
  assign pslverr = psel & penable & ~mapped;     // unmapped access errors

endmodule // pll_synth_divider_control

`default_nettype wire

// File: logic/pll_synth_pkg.sv
// constants and carrier types for the synthesizer divider control block
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package pll_synth_pkg;

  // register byte addresses (one aligned word each)
  localparam logic [7:0] TX_CFG_ADDR   = 8'h04; // transmit loop word
  localparam logic [7:0] RX_CFG_ADDR   = 8'h08; // receive loop word
  localparam logic [7:0] LO2_CFG_ADDR  = 8'h0C; // second oscillator word
  localparam logic [7:0] REF_CFG_ADDR  = 8'h10; // reference and capacitor word
  localparam logic [7:0] STATUS_ADDR   = 8'h14; // live state, read only

  // main loop word fields
  localparam int SWALLOW_LSB = 0;  // 7-bit swallow count
  localparam int SWALLOW_W   = 7;
  localparam int MAIN_LSB    = 7;  // 13-bit main count
  localparam int MAIN_W      = 13;
  localparam int MAIN_GAIN   = 20; // pump gain bit
  localparam int MAIN_POL    = 21; // detector polarity bit

  // second oscillator word fields
  localparam int LO2_CNT_LSB = 0;  // 14-bit counter
  localparam int LO2_CNT_W   = 14;
  localparam int LO2_GAIN    = 14;
  localparam int LO2_POL     = 15;
  localparam int MOD_VMODE   = 16; // modulus drive mode, shared

  // reference word fields
  localparam int REF_CNT_LSB = 0;  // 12-bit reference counter
  localparam int REF_CNT_W   = 12;
  localparam int CAP_LSB     = 18; // 3-bit tank capacitor select
  localparam int CAP_W       = 3;

  // reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // one main loop's configuration
  typedef struct packed {
    logic                 pol;
    logic                 gain;
    logic [MAIN_W-1:0]    main_cnt;
    logic [SWALLOW_W-1:0] swallow_cnt;
  } main_cfg_s;

  // one three-state pump pin: drive level and active-low enable
  typedef struct packed {
    logic drive;
    logic oe_n;
  } pump_s;

endpackage : pll_synth_pkg

// File: tb/pll_synth_divider_control_tb.sv
// self-checking bench for the synthesizer divider control block
`timescale 1ns/1ps
`default_nettype none
module pll_synth_divider_control_tb;
  //----------------------------------------
  // signals
  //----------------------------------------
  logic        core_clk = 1'b0;   // 100 MHz
  logic        rst_n = 1'b0;      // sync reset
  logic        psel = 1'b0;       // apb select
  logic        penable = 1'b0;    // apb access
  logic        pwrite = 1'b0;     // apb direction
  logic [7:0]  paddr = 8'h00;     // apb address
  logic [31:0] pwdata = 32'h0;    // apb write data
  logic [31:0] prdata;            // apb read data
  logic        pready, pslverr, modulus_vmode, lo2_gain_hi, lo2_buf_out;
  logic [1:0]  modulus_ctl, main_gain_hi;
  wire  [1:0]  prescaled_in;      // prescaler model outputs, one bit per model
  logic [1:0]  ph = 2'h0;         // pin phase, ref and vco rise every 4 cycles
  logic [2:0]  lo2_cap_sel;       // tank code
  pll_synth_pkg::pump_s [1:0] main_pump;
  pll_synth_pkg::pump_s       lo2_pump;
  int errors = 0, comparisons = 0, cycles = 0;
  int tx_pulses, tx_longs, rx_pulses, rx_longs; // prescaler model tallies
  int pulses[2], longs[2];        // same tallies indexed by loop
  // gather the tallies so the scenario can walk both loops in one loop
  always_comb begin
    pulses = '{tx_pulses, rx_pulses};
    longs = '{tx_longs, rx_longs};
  end
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) ph <= ph + 2'h1;
  //----------------------------------------
  // design and partners
  //----------------------------------------
  pll_synth_divider_control u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ref_osc_in(ph[1]), .prescaled_in,
    .second_local_osc_vco(ph[1]), .modulus_ctl, .modulus_vmode, .main_pump,
    .main_gain_hi, .lo2_pump, .lo2_gain_hi, .lo2_cap_sel, .lo2_buf_out);
  prescaler_model u_tx_pre (.core_clk, .modulus(modulus_ctl[0]),
    .pulse(prescaled_in[0]), .pulses(tx_pulses), .longs(tx_longs));
  prescaler_model u_rx_pre (.core_clk, .modulus(modulus_ctl[1]),
    .pulse(prescaled_in[1]), .pulses(rx_pulses), .longs(rx_longs));
  //----------------------------------------
  // tasks
  //----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer: setup, then access held until pready is sampled
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [32:0] re);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // no own limit: only the bench timeout may end this wait
    while (pready !== 1'b1) @(posedge core_clk);
    re = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [32:0] re;
    apb(1'b1, a, d, re);
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp, logic e);
    logic [32:0] re;
    apb(1'b0, a, 32'h0, re);
    chk(nm, exp, re[31:0]);
    chk(nm, {31'h0, e}, {31'h0, re[32]});
  endtask
  // configure both main loops, then watch modulus share and pump sense
  task automatic run_div(int tm, ts, tp, rm, rs, rp);
    int m[2] = '{tm, rm};
    int s[2] = '{ts, rs};
    int p0[2] = pulses;
    int l0[2] = longs;
    int agree[3] = '{0, 0, 0};
    int other[3] = '{0, 0, 0};
    logic [2:0] pol = {tp[0], rp[0], tp[0]}; // second loop polarity follows tx
    int dp, dl;
    bit ok;
    wr(8'h04, (tp << 21) | (tm << 7) | ts);
    wr(8'h08, (rp << 21) | (rm << 7) | rs);
    wr(8'h0C, (tp << 15) | 32'h0000_0002);
    wr(8'h10, 32'h0000_0014);
    repeat (200) @(posedge core_clk);
    p0 = pulses;
    l0 = longs;
    repeat (2000) begin
      @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
        if (lo2_pump.oe_n === 1'b0 && i == 2 || main_pump[i%2].oe_n === 1'b0 && i < 2) begin
          if ((i == 2 ? lo2_pump.drive : main_pump[i%2].drive) === pol[i]) agree[i]++;
          else other[i]++;
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      dp = pulses[i] - p0[i];
      dl = longs[i] - l0[i];
      ok = (dl*m[i]-dp*s[i])**2 <= (2*m[i]*s[i]+m[i])**2;
      chk("modulus_share", 1, {31'h0, ok});
    end
    for (int i = 0; i < 3; i++) chk("pump_sense", 1, {31'h0, agree[i] > other[i]});
    $display("test divide run done");
  endtask
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    // pumps are only guaranteed idle in reset: zero counts tick at once after it
    chk("pump_idle", 32'h7,
        {29'h0, lo2_pump.oe_n, main_pump[1].oe_n, main_pump[0].oe_n});
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 1; i < 5; i++) rd_chk("cfg_reset", 8'(4*i), 32'h0, 1'b0);
    wr(8'h04, 32'hFFF0_007F);
    rd_chk("tx_word", 8'h04, 32'h0030_007F, 1'b0);
    wr(8'h08, 32'hFFF0_007F);
    rd_chk("rx_word", 8'h08, 32'h0030_007F, 1'b0);
    wr(8'h0C, 32'hFFFF_C000);
    rd_chk("lo2_word", 8'h0C, 32'h0001_C000, 1'b0);
    wr(8'h10, 32'hFFFF_F000);
    rd_chk("ref_word", 8'h10, 32'h001C_0000, 1'b0);
    chk("cfg_pins", 32'h7F,
        {25'h0, main_gain_hi, lo2_gain_hi, modulus_vmode, lo2_cap_sel});
    wr(8'h18, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h18, 32'h0, 1'b1);
    rd_chk("unmapped", 8'h00, 32'h0, 1'b1);
    $display("test registers done");
    run_div(3, 1, 0, 5, 2, 1);
    run_div(4, 0, 1, 6, 3, 0);
    print_verdict();
  end
endmodule // pll_synth_divider_control_tb
`default_nettype wire

// File: tb/pll_synth_props.sv
// concurrent checks on the synthesizer divider control ports
`timescale 1ns/1ps
`default_nettype none
module pll_synth_props (
  input wire logic                  core_clk,     // clock
  input wire logic                  rst_n,        // sync reset
  input wire logic                  psel,         // apb select
  input wire logic                  penable,      // apb access
  input wire logic                  pwrite,       // apb direction
  input wire logic [7:0]            paddr,        // apb address
  input wire logic [31:0]           pwdata,       // apb write data
  input wire logic [31:0]           prdata,       // apb read data
  input wire logic                  pready,       // apb ready
  input wire logic                  pslverr,      // apb error
  input wire logic                  ref_osc_in,   // reference pin
  input wire logic [1:0]            prescaled_in, // prescaler pins
  input wire logic                  second_local_osc_vco, // vco pin
  input wire logic [1:0]            modulus_ctl,  // modulus pins
  input wire logic                  modulus_vmode, // drive mode
  input wire pll_synth_pkg::pump_s [1:0] main_pump, // main pumps
  input wire logic [1:0]            main_gain_hi, // main gains
  input wire pll_synth_pkg::pump_s  lo2_pump,     // second pump
  input wire logic                  lo2_gain_hi,  // second gain
  input wire logic [2:0]            lo2_cap_sel,  // tank cap code
  input wire logic                  lo2_buf_out   // buffered vco
);
  //----------------------------------------
  // helper logic
  //----------------------------------------
  logic [2:0] since_rst; // saturating age since reset, masks sync flops
  logic [3:0] since_tx;  // cycles since tx prescaler pin rose
  logic       tx_q;      // last tx pin level
  wire        mapped = paddr inside {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  // ages are counted here so the assertions stay bounded
  always_ff @(posedge core_clk) begin
    tx_q <= prescaled_in[0];
    since_rst <= !rst_n ? 3'h0 : since_rst + {2'h0, since_rst != 3'h7};
    since_tx <= (prescaled_in[0] && !tx_q) ? 4'h0 : since_tx + {3'h0, since_tx != 4'hF};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  //----------------------------------------
  // properties
  //----------------------------------------
  sequence s_cfg_write(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  // a written field reaches its pin exactly two edges later
  property p_lands(logic [7:0] a, logic [2:0] d, logic [2:0] q);
    logic [2:0] v;
    (s_cfg_write(a), v = d) |-> ##2 (q == v);
  endproperty
  a_pready_high: assert property (
    pready)
    else $error("pready low");
  a_slverr_decode: assert property (
    pslverr == (psel && penable && !mapped))
    else $error("pslverr decode wrong");
  a_vmode_write: assert property (
    p_lands(8'h0C, {2'h0, pwdata[16]}, {2'h0, modulus_vmode}))
    else $error("modulus drive mode not applied");
  a_tx_gain_write: assert property (
    p_lands(8'h04, {2'h0, pwdata[20]}, {2'h0, main_gain_hi[0]}))
    else $error("tx pump gain not applied");
  a_rx_gain_write: assert property (
    p_lands(8'h08, {2'h0, pwdata[20]}, {2'h0, main_gain_hi[1]}))
    else $error("rx pump gain not applied");
  a_lo2_gain_write: assert property (
    p_lands(8'h0C, {2'h0, pwdata[14]}, {2'h0, lo2_gain_hi}))
    else $error("second pump gain not applied");
  a_cap_write: assert property (
    p_lands(8'h10, pwdata[20:18], lo2_cap_sel))
    else $error("tank capacitor code not applied");
  a_buf_follows: assert property (
    since_rst == 3'h7 |-> lo2_buf_out == $past(second_local_osc_vco, 3))
    else $error("buffered output not following vco");
  a_modulus_cause: assert property (
    $changed(modulus_ctl[0]) |-> since_tx <= 4'hA)
    else $error("modulus moved without prescaler edge");
endmodule // pll_synth_props
bind pll_synth_divider_control pll_synth_props u_props (.core_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_osc_in, .prescaled_in,
  .second_local_osc_vco, .modulus_ctl, .modulus_vmode, .main_pump, .main_gain_hi,
  .lo2_pump, .lo2_gain_hi, .lo2_cap_sel, .lo2_buf_out);
`default_nettype wire

// File: tb/prescaler_model.sv
// behavioural dual-modulus prescaler outside one main loop
`timescale 1ns/1ps
`default_nettype none
module prescaler_model #(
  parameter int P = 8 // input counts per low-modulus period
) (
  input  wire logic core_clk, // vco stand-in, one count per cycle
  input  wire logic modulus,  // 1 selects the long period
  output var  logic pulse,    // divided output to the block
  output var  int   pulses,   // periods started
  output var  int   longs     // periods started at high modulus
);
  int cnt = 0; // counts left in this period
  initial begin
    pulse = 1'b0;
    pulses = 0;
    longs = 0;
  end
  // modulus is sampled once per period, like a real prescaler latch
  always @(posedge core_clk) begin
    if (cnt == 0) begin
      cnt <= modulus ? P : P - 1;
      pulses <= pulses + 1;
      longs <= longs + int'(modulus);
    end else begin
      cnt <= cnt - 1;
    end
    pulse <= cnt >= P / 2; // one rise per period, never faster than 2 clocks
  end
endmodule // prescaler_model
`default_nettype wire
